//--- rtl/reset_sequence_manager.sv
// Reset sequence manager with open-drain reset pin and clock pre-stage.
`timescale 1ns/1ns
`default_nettype none
`include "reset_seq_consts.svh"
module reset_sequence_manager
    import reset_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic reset_pin_in,
    input wire logic low_voltage_detect_in,
    input wire logic watchdog_reset_in,
    input wire logic long_delay_opt_in,
    input wire logic doubler_opt_in,
    input wire logic osc_input_clock_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n_out,
    output logic cpu_reset_out,
    output logic vector_fetch_out,
    output logic [15:0] vector_addr_out,
    output logic delay_phase_out,
    output logic divided_osc_tick_out
);
    seq_state_t state_r, state_nxt;
    logic [`RSQ_CNT_W-1:0] cnt_r, cnt_nxt;
    logic long_r, long_nxt;
    logic drive_r, drive_nxt;
    logic drive_d1_r;
    logic cpu_reset_r, cpu_reset_nxt;
    logic fetch_r, fetch_nxt;
    logic delay_r, delay_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic ext_catch_r;
    logic ext_req, int_req, any_req;
    logic [`RSQ_CNT_W-1:0] limit;

    // Delay length for the latched option.
    function automatic logic [`RSQ_CNT_W-1:0] delay_limit(input logic long_sel);
        delay_limit = long_sel ? `RSQ_DELAY_LONG : `RSQ_DELAY_SHORT;
    endfunction : delay_limit

    // --------------------------------------------------------------
    // External pin catch
    // --------------------------------------------------------------
    // clockless pin catch
    // The pin edge sets the flag on its own, so a stopped clock still sees
    // the reset; it clears on the first clock once the pin is high again.
    always_ff @(posedge clk_in or negedge rstn_in or negedge reset_pin_in) begin
        if (!rstn_in) begin
            ext_catch_r <= 1'b0;
        end else if (!reset_pin_in) begin
            ext_catch_r <= 1'b1;
        end else begin
            ext_catch_r <= 1'b0;
        end
    end

    // Our own pull-down, and the edge just after it, would look like an
    // outside request; the pin is ignored while it is ours.
    assign ext_req = ext_catch_r & ~drive_r & ~drive_d1_r;
    assign int_req = low_voltage_detect_in | watchdog_reset_in;
    assign any_req = int_req | ext_req;
    assign limit = delay_limit(long_r);

    // --------------------------------------------------------------
    // Sequence state machine
    // --------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        long_nxt = long_r;
        case (state_r)
            ST_ACTIVE: begin
                cnt_nxt = '0;
                long_nxt = long_delay_opt_in;
                if (!any_req) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (cnt_r == limit - 1'b1) begin
                    state_nxt = ST_FETCH;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_FETCH: begin
                if (cnt_r == `RSQ_FETCH_CYCLES - 1'b1) begin
                    state_nxt = ST_RUN;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
        if (any_req) begin
            state_nxt = ST_ACTIVE;
            cnt_nxt = '0;
        end
    end

    // Outputs follow the next state so they line up with the state register.
    always_comb begin
        drive_nxt = (state_nxt == ST_DELAY) || (state_nxt == ST_ACTIVE && int_req);
        cpu_reset_nxt = (state_nxt != ST_RUN);
        fetch_nxt = (state_nxt == ST_FETCH);
        delay_nxt = (state_nxt == ST_DELAY);
        addr_nxt = 16'h0000;
        if (fetch_nxt) begin
            addr_nxt = cnt_nxt[0] ? `RSQ_VEC_HI : `RSQ_VEC_LO;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= ST_ACTIVE;
            cnt_r <= '0;
            long_r <= 1'b0;
            drive_r <= 1'b0;
            drive_d1_r <= 1'b0;
            cpu_reset_r <= 1'b1;
            fetch_r <= 1'b0;
            delay_r <= 1'b0;
            addr_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            long_r <= long_nxt;
            drive_r <= drive_nxt;
            drive_d1_r <= drive_r;
            cpu_reset_r <= cpu_reset_nxt;
            fetch_r <= fetch_nxt;
            delay_r <= delay_nxt;
            addr_r <= addr_nxt;
        end
    end

    // --------------------------------------------------------------
    // Pins and status
    // --------------------------------------------------------------
    // open drain, low only
    assign reset_pin_out = `RSQ_PIN_LOW;
    assign reset_pin_oe_n_out = ~drive_r;
    assign cpu_reset_out = cpu_reset_r;
    assign vector_fetch_out = fetch_r;
    assign vector_addr_out = addr_r;
    assign delay_phase_out = delay_r;

    clock_prestage u_prestage (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .osc_input_clock_in(osc_input_clock_in),
        .doubler_opt_in(doubler_opt_in),
        .hold_in(cpu_reset_r),
        .divided_osc_tick_out(divided_osc_tick_out)
    );

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    logic [`RSQ_CNT_W:0] dly_len_h;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dly_len_h <= '0;
        end else if (state_r == ST_DELAY) begin
            dly_len_h <= dly_len_h + 1'b1;
        end else begin
            dly_len_h <= '0;
        end
    end

    property p_pin_delay;
        @(posedge clk_in) disable iff (!rstn_in)
        (state_r == ST_DELAY) |-> !reset_pin_oe_n_out;
    endproperty
    a_pin_delay: assert property (p_pin_delay)
        else $error("reset pin released during the delay phase");

    property p_delay_len;
        @(posedge clk_in) disable iff (!rstn_in)
        (state_r == ST_FETCH && $past(state_r) == ST_DELAY)
            |-> dly_len_h == {1'b0, delay_limit(long_r)};
    endproperty
    a_delay_len: assert property (p_delay_len)
        else $error("delay phase length differs from the option");

    // A fetch that starts with no request pending must run both cycles.
    sequence s_fetch_start;
        $rose(vector_fetch_out) && !any_req;
    endsequence
    sequence s_fetch_lo;
        vector_fetch_out && vector_addr_out == `RSQ_VEC_LO;
    endsequence
    sequence s_fetch_hi;
        vector_fetch_out && vector_addr_out == `RSQ_VEC_HI;
    endsequence
    property p_fetch;
        @(posedge clk_in) disable iff (!rstn_in)
        s_fetch_start |-> s_fetch_lo ##1 s_fetch_hi;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("vector fetch addresses out of order");

    property p_fetch_two;
        @(posedge clk_in) disable iff (!rstn_in)
        s_fetch_start ##1 !any_req |=> !vector_fetch_out && !cpu_reset_out;
    endproperty
    a_fetch_two: assert property (p_fetch_two)
        else $error("fetch phase did not end after two cycles");

    property p_restart;
        @(posedge clk_in) disable iff (!rstn_in)
        any_req |=> state_r == ST_ACTIVE && cpu_reset_out && cnt_r == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("request did not restart the sequence");

    property p_sources;
        @(posedge clk_in) disable iff (!rstn_in)
        (low_voltage_detect_in || watchdog_reset_in) |=> !reset_pin_oe_n_out;
    endproperty
    a_sources: assert property (p_sources)
        else $error("internal reset source did not pull the pin");

    property p_order;
        @(posedge clk_in) disable iff (!rstn_in)
        (state_r == ST_FETCH && $past(state_r) != ST_FETCH) |-> $past(state_r) == ST_DELAY;
    endproperty
    a_order: assert property (p_order)
        else $error("fetch entered without a delay phase");

    property p_ext;
        @(posedge clk_in) disable iff (!rstn_in)
        (ext_catch_r && !drive_r && !drive_d1_r) |=> cpu_reset_out && state_r == ST_ACTIVE;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external pin low did not enter reset");

    property p_low_only;
        @(posedge clk_in) disable iff (!rstn_in)
        !reset_pin_oe_n_out |-> reset_pin_out == `RSQ_PIN_LOW;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("reset pin driven high");
endmodule : reset_sequence_manager
`default_nettype wire

//--- rtl/reset_seq_consts.svh
// Constants of the reset sequencer and its clock pre-stage.
// Behaviour
// - Low-voltage, watchdog and external pin requests all start the reset sequence.
// - The reset pin is pulled low for the whole delay phase, whatever the source.
// - A reset runs an active phase, then a fixed delay phase, then a vector fetch phase.
// - The delay lasts 256 or 4096 clock cycles, chosen by an option fixed at reset.
// - The vector fetch takes exactly two cycles and ends before normal execution.
// - The handler address is fetched from locations FFFE and FFFF.
// - The reset pin is open drain with a pull-up, and outside logic may pull it low.
// - A low on the reset pin is caught without needing a running clock.
// - With the doubler off the divided clock runs at half the oscillator rate.
// - An option turns the doubler on, which then gives twice the oscillator rate.
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH
`define RSQ_CNT_W 13
`define RSQ_DELAY_SHORT 13'h0100
`define RSQ_DELAY_LONG 13'h1000
`define RSQ_FETCH_CYCLES 13'h0002
`define RSQ_VEC_LO 16'hFFFE
`define RSQ_VEC_HI 16'hFFFF
`define RSQ_PIN_LOW 1'h0
`endif

//--- rtl/reset_seq_pkg.sv
// Types shared by the reset sequencer files.
package reset_seq_pkg;
    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_DELAY,
        ST_FETCH,
        ST_RUN
    } seq_state_t;
endpackage : reset_seq_pkg

//--- rtl/clock_prestage.sv
// Clock pre-stage: halves or doubles the oscillator tick rate.
`timescale 1ns/1ns
`default_nettype none
`include "reset_seq_consts.svh"
module clock_prestage (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic osc_input_clock_in,
    input wire logic doubler_opt_in,
    input wire logic hold_in,
    output logic divided_osc_tick_out
);
    logic osc_d_r, osc_d_nxt;
    logic half_r, half_nxt;
    logic dbl_r, dbl_nxt;
    logic tick_r, tick_nxt;
    logic rise, fall;

    // --------------------------------------------------------------
    // Tick generation
    // --------------------------------------------------------------
    // The oscillator is sampled as a level; rate is counted in ticks.
    assign rise = osc_input_clock_in & ~osc_d_r;
    assign fall = ~osc_input_clock_in & osc_d_r;

    // The option is only taken while the core is held in reset, so the
    // rate cannot change under running code.
    always_comb begin
        osc_d_nxt = osc_input_clock_in;
        dbl_nxt = hold_in ? doubler_opt_in : dbl_r;
        half_nxt = half_r;
        tick_nxt = 1'b0;
        if (dbl_r) begin
            tick_nxt = rise | fall;
        end else if (rise) begin
            half_nxt = ~half_r;
            tick_nxt = half_r;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osc_d_r <= 1'b0;
            half_r <= 1'b0;
            dbl_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            osc_d_r <= osc_d_nxt;
            half_r <= half_nxt;
            dbl_r <= dbl_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign divided_osc_tick_out = tick_r;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_half_rate;
        @(posedge clk_in) disable iff (!rstn_in)
        (!dbl_r && rise && !half_r) |=> !tick_r;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("tick produced on the first of two oscillator edges");

    property p_double_rate;
        @(posedge clk_in) disable iff (!rstn_in)
        (dbl_r && (rise || fall)) |=> tick_r;
    endproperty
    a_double_rate: assert property (p_double_rate)
        else $error("doubler missed an oscillator edge");
endmodule : clock_prestage
`default_nettype wire

//--- verif/reset_pin_partner.sv
// Model of the outside circuitry on the shared open-drain reset pin.
`timescale 1ns/1ns
`default_nettype none
module reset_pin_partner (
    input wire logic ext_pull_low_in,
    input wire logic dev_pin_value_in,
    input wire logic dev_pin_oe_n_in,
    output logic pin_level_out
);
    // ----------------------------------------
    // Wire resolution
    // ----------------------------------------
    // open drain wire
    // The weak pull-up wins only when nobody pulls low, so the pin never floats.
    always_comb begin
        pin_level_out = 1'b1;
        if (!dev_pin_oe_n_in && dev_pin_value_in == 1'b0) begin
            pin_level_out = 1'b0;
        end
        if (ext_pull_low_in) begin
            pin_level_out = 1'b0;
        end
    end
endmodule : reset_pin_partner
`default_nettype wire

//--- verif/reset_sequence_manager_bench.sv
// Self-checking bench of the reset sequence manager.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module reset_sequence_manager_bench;
    logic clk_in;
    logic rstn_in;
    logic clk_run = 1'b1;
    logic pin_level, ext_pull, low_voltage_detect, wdg, long_opt, dbl_opt, osc;
    logic pin_out, oe_n, cpu_rst, fetch, dly, tick;
    logic [15:0] addr;
    logic [31:0] rnd = 32'h000108B6;
    int bad_count = 0;
    int check_count = 0;
    int exp_q[$];
    int tick_q[$];
    int dly_cnt = 0;
    int fidx = 0;
    int tick_cnt = 0;
    int exp_v;

    reset_sequence_manager u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .reset_pin_in(pin_level), .low_voltage_detect_in(low_voltage_detect), .watchdog_reset_in(wdg),
        .long_delay_opt_in(long_opt), .doubler_opt_in(dbl_opt), .osc_input_clock_in(osc),
        .reset_pin_out(pin_out), .reset_pin_oe_n_out(oe_n), .cpu_reset_out(cpu_rst),
        .vector_fetch_out(fetch), .vector_addr_out(addr), .delay_phase_out(dly),
        .divided_osc_tick_out(tick));
    reset_pin_partner u_pin (.ext_pull_low_in(ext_pull), .dev_pin_value_in(pin_out),
        .dev_pin_oe_n_in(oe_n), .pin_level_out(pin_level));

    // ----------------------------------------
    // Clock, oscillator and helpers
    // ----------------------------------------
    // The clock can be frozen to mimic the clock-stopped halt state.
    always #50 if (clk_run) clk_in = ~clk_in;

    // Oscillator toggles every four cycles, well below half the clock rate.
    initial begin
        osc = 1'b0;
        forever begin
            repeat (4) @(posedge clk_in);
            #10 osc = ~osc;
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #10;
    endtask : cyc

    // Bounded wait for the core to leave reset.
    task automatic wait_run();
        int n;
        n = 0;
        while (cpu_rst !== 1'b0 && n < 6000) begin
            cyc(1);
            n++;
        end
        `CHK(cpu_rst, 1'b0)
    endtask : wait_run

    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    // Sampling on the falling edge keeps every compare clear of update races.
    always @(negedge clk_in) begin
        if (rstn_in) begin
            tick_cnt++;
            if (tick) begin
                // The note is popped once, so a mismatch cannot eat a second one.
                if (tick_q.size() > 0) begin
                    exp_v = tick_q.pop_front();
                    `CHK(tick_cnt, exp_v)
                end
                tick_cnt = 0;
            end
            if (dly) begin
                dly_cnt++;
                `CHK({oe_n, pin_out}, 2'h0)
            end else begin
                if (fetch) begin
                    if (fidx == 0) begin
                        `CHK(exp_q.size() > 0, 1'b1)
                        if (exp_q.size() > 0) begin
                            exp_v = exp_q.pop_front();
                            `CHK(dly_cnt, exp_v)
                        end
                    end
                    `CHK(fidx < 2, 1'b1)
                    `CHK(addr, fidx == 0 ? 16'hFFFE : 16'hFFFF)
                    fidx++;
                end else begin
                    if (fidx == 2) `CHK({cpu_rst, addr}, 17'h00000)
                    fidx = 0;
                end
                dly_cnt = 0;
            end
        end
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        rstn_in = 1'b0;
        ext_pull = 1'b0;
        low_voltage_detect = 1'b0;
        wdg = 1'b0;
        long_opt = 1'b0;
        dbl_opt = 1'b0;
        exp_q.push_back(256);
        cyc(2);
        `CHK({oe_n, cpu_rst, fetch}, 3'h6)
        cyc(1);
        rstn_in = 1'b1;
        wait_run();
        tick_q = '{16, 16, 16};
        rnd = lfsr_next(rnd);
        low_voltage_detect = 1'b1;
        long_opt = rnd[3];
        cyc(2 + int'(rnd[2:0]));
        `CHK({cpu_rst, dly}, 2'h2)
        low_voltage_detect = 1'b0;
        exp_q.push_back(rnd[3] ? 4096 : 256);
        wait_run();
        long_opt = 1'b1;
        wdg = 1'b1;
        exp_q.push_back(4096);
        cyc(1);
        wdg = 1'b0;
        cyc(1);
        `CHK(cpu_rst, 1'b1)
        wait_run();
        long_opt = 1'b0;
        rnd = lfsr_next(rnd);
        low_voltage_detect = 1'b1;
        cyc(1);
        low_voltage_detect = 1'b0;
        cyc(12 + int'(rnd[5:0]));
        `CHK(dly, 1'b1)
        // The pulse is seen at the next edge; the delay restarts one edge later.
        wdg = 1'b1;
        cyc(1);
        `CHK(dly, 1'b0)
        wdg = 1'b0;
        cyc(1);
        exp_q.push_back(256);
        wait_run();
        ext_pull = 1'b1;
        cyc(2);
        `CHK({cpu_rst, oe_n, dly}, 3'h6)
        cyc(3);
        ext_pull = 1'b0;
        exp_q.push_back(256);
        wait_run();
        // pin pulse while the clock is frozen
        @(negedge clk_in);
        #10 clk_run = 1'b0;
        #100 ext_pull = 1'b1;
        #200 ext_pull = 1'b0;
        #100 clk_run = 1'b1;
        exp_q.push_back(256);
        cyc(3);
        `CHK(cpu_rst, 1'b1)
        wait_run();
        // doubler taken while the core is held
        dbl_opt = 1'b1;
        low_voltage_detect = 1'b1;
        cyc(1);
        low_voltage_detect = 1'b0;
        exp_q.push_back(256);
        cyc(1);
        wait_run();
        // Dropping the option while code runs must leave the doubled rate alone.
        dbl_opt = 1'b0;
        cyc(20);
        tick_q = '{4, 4, 4, 4};
        cyc(40);
        `CHK(tick_q.size() + exp_q.size(), 0)
        complete_run();
    end

    // Watchdog sized well above the run length, two long delays included.
    initial begin
        #(20000 * 100);
        bad_count++;
        complete_run();
    end
endmodule : reset_sequence_manager_bench
`default_nettype wire
